// ==== rtl/sar_adc_serial_conversion_ctrl.sv ====
// How it works
// - new data bit launched on serial clock rise
// - convert_start fall samples input, enters hold
// - back to tracking on fourteenth rising edge
// - tracking straight after power-up
// - first full conversion calibrates, result not used
// - convert_start fall drives data line, low unless an early raise cut the last frame short
// - serial clock paces sar, bits shown when decided
// - three zeros, then msb from fourth edge
// - raise between edges 14 and 16 keeps driving
// - low after edge 16 releases line next edge
// - raise between edges 3 and 14 powers down
// - low for fourteen clocks leaves partial power-down
// - second early raise from partial gives full sleep
// - low for fourteen clocks leaves full power-down
// - unipolar straight binary, bipolar twos complement
// - frame is three zeros, 12 bits, one zero
// - partial wake needs sixteen serial clocks
// - full wake needs two milliseconds
`timescale 1ns/100ps
module sar_adc_serial_conversion_ctrl #(
    parameter bit BIPOLAR = 1'b0,
    parameter int FULL_WAKE_CYCLES_P = sar_adc_pkg::FULL_WAKE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_serial_clock,
    input wire logic i_convert_start,
    input wire logic i_cmp_high,
    output logic o_sdo,
    output logic o_sdo_oe_b,
    output logic o_track_hold,
    output logic [sar_adc_pkg::RESULT_W-1:0] o_dac_code,
    output logic [sar_adc_pkg::RESULT_W-1:0] o_result,
    output logic o_result_valid,
    output logic [1:0] o_power_mode,
    output logic o_conv_ready
);
    import sar_adc_pkg::*;

    localparam int WAKE_W = $clog2(FULL_WAKE_CYCLES_P + 1);
    localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(FULL_WAKE_CYCLES_P);
    localparam logic [WAKE_W-1:0] WAKE_ZERO = '0;

    // one sar step: keep or drop the trial bit, set the next trial bit
    function automatic logic [11:0] sar_step(input logic [11:0] code,
                                             input logic [3:0] bit_no,
                                             input logic keep);
        logic [11:0] next_code;
        next_code = code;
        next_code[bit_no] = keep;
        if (bit_no != 4'h0) begin
            next_code[bit_no - 4'h1] = 1'b1;
        end
        return next_code;
    endfunction : sar_step

    // ****************************************************************
    // link domain: reset synchroniser
    // ****************************************************************
    logic lrst_meta_b; // first stage, read only by the second
    logic lrst_b; // reset as seen by serial clock logic

    // the serial clock may stand still, so reset takes hold at its edges
    always_ff @(posedge i_serial_clock) begin
        lrst_meta_b <= i_rst_b;
        lrst_b <= lrst_meta_b;
    end

    // ****************************************************************
    // link domain: frame decode
    // ****************************************************************
    link_state_e state_q; // frame state
    power_mode_e mode_q; // power mode kept at the link
    logic [4:0] cnt_q; // rising edges seen in this frame
    logic cs_q; // convert_start at the previous rising edge
    logic hold_q; // track/hold in hold
    logic keep_q; // line kept driven between frames
    logic cont_q; // raise seen between edges 14 and 16
    logic frame_norm_q; // frame started awake and ready
    logic cal_q; // calibration conversion done
    logic [4:0] rcv_cnt_q; // partial wake clocks left
    logic [11:0] dac_q; // sar trial code
    logic [11:0] res_q; // last published result
    logic res_tgl_q; // toggles once per published result
    logic sdo_q; // data bit on the line

    // the host raises convert_start first, so a fall needs cs_q high
    wire start_fall = (state_q == LINK_IDLE) && cs_q
        && !i_convert_start;
    wire in_conv = (state_q == LINK_CONVERT);
    wire [4:0] edge_no = cnt_q + 5'h01; // number of this rising edge
    wire early_raise = in_conv && i_convert_start
        && (edge_no > EDGE_LEAD) && (edge_no <= EDGE_TRACK);
    wire deciding = in_conv && (edge_no >= EDGE_MSB)
        && (edge_no <= EDGE_LSB);
    wire [3:0] bit_no = 4'(EDGE_LSB - edge_no);
    wire complete = deciding && (edge_no == EDGE_LSB);
    wire frame_end = in_conv && !early_raise
        && (edge_no == EDGE_LAST);
    wire cont_seen = in_conv && i_convert_start
        && (edge_no > EDGE_TRACK);
    // fourteen low clocks without an early raise end either sleep
    wire wake_exit = in_conv && !early_raise && (edge_no == EXIT_EDGES)
        && (mode_q != PWR_NORMAL);
    wire [11:0] next_dac = sar_step(dac_q, bit_no, i_cmp_high);
    wire msb_flip = BIPOLAR && (bit_no == 4'hB);
    wire [11:0] code_fmt = BIPOLAR ? MSB_FLIP : RESULT_RESET;
    wire link_ready = cal_q && (rcv_cnt_q == COUNT_RESET)
        && (mode_q == PWR_NORMAL);
    wire tail = (state_q == LINK_TAIL);

    // ****************************************************************
    // link domain: frame state and edge counter
    // ****************************************************************
    link_state_e next_state;

    // next frame state from the counter and convert_start
    always_comb begin
        next_state = state_q;
        case (state_q)
            LINK_IDLE: begin
                if (start_fall) begin
                    next_state = LINK_CONVERT;
                end
            end
            LINK_CONVERT: begin
                if (early_raise) begin
                    next_state = LINK_IDLE;
                end else if (frame_end) begin
                    // still low after edge 16: release at next edge
                    next_state = (cont_q || cont_seen) ? LINK_IDLE
                        : LINK_TAIL;
                end
            end
            LINK_TAIL: begin
                next_state = LINK_IDLE;
            end
            default: begin
                next_state = LINK_IDLE;
            end
        endcase
    end

    // state, counter and the sampled strobe
    always_ff @(posedge i_serial_clock) begin
        if (!lrst_b) begin
            state_q <= LINK_IDLE;
            cnt_q <= COUNT_RESET;
            cs_q <= 1'b0;
        end else begin
            state_q <= next_state;
            cs_q <= i_convert_start;
            // the edge that sees the fall is edge one
            if (start_fall) begin
                cnt_q <= EDGE_FIRST;
            end else if (in_conv) begin
                cnt_q <= edge_no;
            end
        end
    end

    // ****************************************************************
    // link domain: power modes
    // ****************************************************************
    power_mode_e next_mode;

    // early raise steps one level deeper, long low wakes up
    always_comb begin
        next_mode = mode_q;
        if (early_raise) begin
            case (mode_q)
                PWR_NORMAL: next_mode = PWR_PARTIAL;
                PWR_PARTIAL: next_mode = PWR_FULL;
                PWR_FULL: next_mode = PWR_FULL;
                default: next_mode = PWR_PARTIAL;
            endcase
        end else if (wake_exit) begin
            next_mode = PWR_NORMAL;
        end
    end

    // mode and the partial wake counter
    always_ff @(posedge i_serial_clock) begin
        if (!lrst_b) begin
            mode_q <= PWR_NORMAL;
            rcv_cnt_q <= COUNT_RESET;
        end else begin
            mode_q <= next_mode;
            if (wake_exit && (mode_q == PWR_PARTIAL)) begin
                rcv_cnt_q <= PARTIAL_WAKE_CYCLES;
            end else if (rcv_cnt_q != COUNT_RESET) begin
                rcv_cnt_q <= rcv_cnt_q - 5'h01;
            end
        end
    end

    // ****************************************************************
    // link domain: track/hold and line drive
    // ****************************************************************

    // hold from the fall until edge 14, or until an aborting raise
    always_ff @(posedge i_serial_clock) begin
        if (!lrst_b) begin
            hold_q <= 1'b0;
            keep_q <= 1'b0;
            cont_q <= 1'b0;
        end else begin
            if (start_fall) begin
                hold_q <= 1'b1;
            end else if (early_raise || (in_conv
                && edge_no == EDGE_TRACK)) begin
                hold_q <= 1'b0;
            end
            if (start_fall) begin
                keep_q <= 1'b0;
                cont_q <= 1'b0;
            end else begin
                if (cont_seen) begin
                    cont_q <= 1'b1;
                end
                if (frame_end && (cont_q || cont_seen)) begin
                    keep_q <= 1'b1;
                end
            end
        end
    end

    // start_fall is used directly so hold and drive begin at the fall,
    // not one serial clock later
    assign o_track_hold = hold_q || start_fall;
    assign o_sdo_oe_b = !(start_fall || in_conv || keep_q
        || (tail && !i_convert_start));

    // ****************************************************************
    // link domain: sar and shift out
    // ****************************************************************

    // each bit goes out on the rising edge that decides it
    always_ff @(posedge i_serial_clock) begin
        if (!lrst_b) begin
            sdo_q <= 1'b0;
            dac_q <= RESULT_RESET;
        end else begin
            if (start_fall) begin
                sdo_q <= 1'b0;
                dac_q <= RESULT_RESET;
            end else if (deciding) begin
                sdo_q <= i_cmp_high ^ msb_flip;
                dac_q <= next_dac;
            end else if (in_conv) begin
                sdo_q <= 1'b0;
                if (edge_no == EDGE_LEAD) begin
                    dac_q <= MSB_TRIAL;
                end
            end
        end
    end

    assign o_sdo = sdo_q;
    assign o_dac_code = dac_q;

    // ****************************************************************
    // link domain: calibration and result publication
    // ****************************************************************

    // results of the calibration frame or a wake frame are dropped
    always_ff @(posedge i_serial_clock) begin
        if (!lrst_b) begin
            cal_q <= 1'b0;
            frame_norm_q <= 1'b0;
            res_q <= RESULT_RESET;
            res_tgl_q <= 1'b0;
        end else begin
            if (start_fall) begin
                frame_norm_q <= link_ready;
            end
            if (complete) begin
                cal_q <= 1'b1;
                if (frame_norm_q) begin
                    res_q <= next_dac ^ code_fmt;
                    res_tgl_q <= !res_tgl_q;
                end
            end
        end
    end

    // ****************************************************************
    // system domain: crossings
    // ****************************************************************
    logic tgl_meta; // first stage of result toggle
    logic tgl_sync; // result toggle in system domain
    logic tgl_prev; // for the edge of tgl_sync
    logic [1:0] mode_meta; // first stage of mode
    logic [1:0] mode_sync; // mode in system domain
    logic [1:0] mode_prev; // previous mode_sync, for the agree filter
    logic rdy_meta; // first stage of link ready
    logic rdy_sync; // link ready in system domain

    // res_q stays still for a whole frame after the toggle moves,
    // so the word is safe to take once the toggle has crossed
    always_ff @(posedge i_sys_clk) begin
        tgl_meta <= res_tgl_q;
        tgl_sync <= tgl_meta;
        mode_meta <= mode_q;
        mode_sync <= mode_meta;
        rdy_meta <= link_ready;
        rdy_sync <= rdy_meta;
    end

    // ****************************************************************
    // system domain: full wake timer and outputs
    // ****************************************************************
    logic [WAKE_W-1:0] wake_cnt_q; // full wake clocks left
    logic [1:0] mode_sys_q; // accepted mode

    // full to normal flips both mode bits, so a value is only taken
    // once two samples agree
    wire mode_stable = (mode_sync == mode_prev);
    wire full_left = mode_stable && (mode_sys_q == PWR_FULL)
        && (mode_sync == PWR_NORMAL);
    wire new_result = tgl_sync ^ tgl_prev;
    wire ready_now = rdy_sync && (mode_sys_q == PWR_NORMAL)
        && (wake_cnt_q == WAKE_ZERO);

    // accepted mode, wake timer, result and ready
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            tgl_prev <= 1'b0;
            mode_prev <= PWR_NORMAL;
            mode_sys_q <= PWR_NORMAL;
            wake_cnt_q <= WAKE_ZERO;
            o_result <= RESULT_RESET;
            o_result_valid <= 1'b0;
            o_conv_ready <= 1'b0;
        end else begin
            tgl_prev <= tgl_sync;
            mode_prev <= mode_sync;
            if (mode_stable) begin
                mode_sys_q <= mode_sync;
            end
            if (full_left) begin
                wake_cnt_q <= WAKE_LOAD;
            end else if (wake_cnt_q != WAKE_ZERO) begin
                wake_cnt_q <= wake_cnt_q - WAKE_W'(1'b1);
            end
            if (new_result && ready_now) begin
                o_result <= res_q;
            end
            o_result_valid <= new_result && ready_now;
            o_conv_ready <= ready_now;
        end
    end

    assign o_power_mode = mode_sys_q;

endmodule : sar_adc_serial_conversion_ctrl

// ==== rtl/sar_adc_pkg.sv ====
// ****************************************************************
// constants shared by the serial converter control
// ****************************************************************
package sar_adc_pkg;

    // system clock rate, used to turn wake times into cycles
    localparam int SYS_CLK_HZ = 25_000_000;
    // wake time out of full power-down, in milliseconds
    localparam int FULL_WAKE_TIME_MS = 2;
    // the same wait counted in system clocks
    localparam int FULL_WAKE_CYCLES = FULL_WAKE_TIME_MS * (SYS_CLK_HZ / 1000);
    // restart time out of partial power-down, in serial clocks
    localparam logic [4:0] PARTIAL_WAKE_CYCLES = 5'h10;

    // result width
    localparam int RESULT_W = 12;

    // serial clock rising-edge numbers within one frame
    localparam logic [4:0] EDGE_FIRST = 5'h01;  // edge that sees the fall
    localparam logic [4:0] EDGE_LEAD = 5'h03;   // last leading zero
    localparam logic [4:0] EDGE_MSB = 5'h04;    // msb decided and shown
    localparam logic [4:0] EDGE_TRACK = 5'h0E;  // back to tracking
    localparam logic [4:0] EDGE_LSB = 5'h0F;    // lsb decided and shown
    localparam logic [4:0] EDGE_LAST = 5'h10;   // trailing zero
    localparam logic [4:0] EXIT_EDGES = 5'h0E;  // low time to leave sleep

    // values after reset and fixed codes
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [11:0] MSB_TRIAL = 12'h800;   // first sar trial
    localparam logic [11:0] MSB_FLIP = 12'h800;    // offset to twos compl.
    localparam logic [4:0] COUNT_RESET = 5'h00;

    // power modes, gray along normal -> partial -> full
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_PARTIAL = 2'b01,
        PWR_FULL = 2'b11
    } power_mode_e;

    // link frame states, gray along idle -> convert -> tail
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_CONVERT = 2'b01,
        LINK_TAIL = 2'b11
    } link_state_e;

endpackage : sar_adc_pkg

// ==== dv/sar_adc_ctrl_sva.sv ====
`timescale 1ns/100ps
// ******************************
// pin checks for the converter
// ******************************
module sar_adc_ctrl_checker #(
    parameter bit BIPOLAR = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_serial_clock,
    input wire logic i_convert_start,
    input wire logic i_cmp_high,
    input wire logic o_sdo,
    input wire logic o_sdo_oe_b,
    input wire logic o_track_hold,
    input wire logic o_result_valid,
    input wire logic [1:0] o_power_mode
);
    logic [4:0] cnt;  // serial rises since the start fall
    logic live;  // frame running, not cut short
    logic norm;  // frame began awake, so its bits mean something
    wire [4:0] next_cnt = (cnt == 5'h1F) ? cnt : cnt + 5'h01;
    wire early = i_convert_start && next_cnt >= 5'h04 && next_cnt <= 5'h0E;
    wire run = live && norm;
    // same edge count as the converter; an early raise ends the frame
    always_ff @(posedge i_serial_clock) begin
        if (!i_rst_b) begin
            cnt <= 5'h00;
            live <= 1'b0;
        end else if ($fell(i_convert_start)) begin
            cnt <= 5'h01;
            live <= 1'b1;
            norm <= (o_power_mode == 2'b00);
        end else begin
            cnt <= next_cnt;
            live <= live && !early;
        end
    end
    a_hold_early: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b) run && cnt != 0 && cnt <= 13 |-> o_track_hold)
        else $error("not holding");
    a_track_at_14: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b) run && cnt == 5'h0E |-> !o_track_hold)
        else $error("not tracking after edge 14");
    a_lead_zeros: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b) run && cnt != 0 && cnt <= 3 |-> !o_sdo)
        else $error("leading bit not zero");
    a_bit_decided: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b) run && cnt >= 4 && cnt <= 15
        |-> o_sdo == ($past(i_cmp_high) ^ (BIPOLAR && cnt == 5'h04)))
        else $error("data bit differs from decision");
    a_tail_zero: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b) run && cnt == 5'h10 |-> !o_sdo)
        else $error("trailing bit not zero");
    a_line_driven: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b)
        run && cnt != 0 && cnt <= 16 && !i_convert_start |-> !o_sdo_oe_b)
        else $error("line released inside frame");
    a_tail_release: assert property (@(posedge i_serial_clock)
        disable iff (!i_rst_b) run && cnt == 5'h10 && !i_convert_start
        && !$past(i_convert_start) |=> o_sdo_oe_b)
        else $error("line not released after frame");
    a_deep_step: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) $changed(o_power_mode) && o_power_mode == 2'b11
        |-> $past(o_power_mode) == 2'b01)
        else $error("full sleep not entered from partial");
    // main scenarios reached
    cover property (@(posedge i_sys_clk) o_result_valid);
    cover property (@(posedge i_sys_clk) o_power_mode == 2'b11);
    cover property (@(posedge i_serial_clock) run && cnt == 5'h10);
endmodule : sar_adc_ctrl_checker

bind sar_adc_serial_conversion_ctrl sar_adc_ctrl_checker #(
    .BIPOLAR(BIPOLAR)
) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_serial_clock(i_serial_clock), .i_convert_start(i_convert_start),
    .i_cmp_high(i_cmp_high), .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b),
    .o_track_hold(o_track_hold), .o_result_valid(o_result_valid),
    .o_power_mode(o_power_mode)
);

// ==== dv/sar_host_model.sv ====
`timescale 1ns/100ps
// ******************************
// host end of the three-wire link
// ******************************
module sar_host_model (
    output logic o_serial_clock,
    output logic o_convert_start,
    input wire logic i_sdo,
    input wire logic i_sdo_oe_b
);
    logic [15:0] word;  // first sixteen bits of the last frame
    // clock parked low, strobe parked high between frames
    initial begin
        o_serial_clock = 1'b0;
        o_convert_start = 1'b1;
    end
    // one 64 ns period; otherwise the clock stands still
    task automatic tick();
        #32 o_serial_clock = 1'b1;
        #32 o_serial_clock = 1'b0;
    endtask : tick
    // start fall, then n rises; strobe rises ahead of edge hi
    task automatic frame(input int n, input int hi);
        tick();  // converter must see the strobe high first
        #4 o_convert_start = 1'b0;
        word = 16'h0000;
        for (int k = 1; k <= n; k++) begin
            if (k == hi) o_convert_start = 1'b1;
            #32 o_serial_clock = 1'b1;
            // a released line reads as the inverse of the last bit
            #32 if (k <= 16) begin
                word = {word[14:0], i_sdo_oe_b ? ~word[0] : i_sdo};
            end
            o_serial_clock = 1'b0;
        end
    endtask : frame
    // strobe back high half a period after the last fall
    task automatic park();
        #32 o_convert_start = 1'b1;
    endtask : park
endmodule : sar_host_model

// ==== dv/sar_adc_serial_conversion_ctrl_test.sv ====
`timescale 1ns/100ps
// ******************************
// converter control bench
// ******************************
module sar_adc_serial_conversion_ctrl_test;
    import sar_adc_pkg::*;
    localparam int WAKE = 40;  // shortened full wake, system clocks
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_cmp_high = 1'b0;
    logic [11:0] vin = 12'h000;  // analog input as a code
    logic [11:0] got;  // last published result
    wire serial_clock, convert_start, o_sdo, o_sdo_oe_b, o_track_hold;
    wire o_result_valid, o_conv_ready;
    wire [11:0] o_dac_code, o_result;
    wire [1:0] o_power_mode;
    logic cmp_bip = 1'b0;  // comparator of the bipolar copy
    logic [11:0] got_bip;  // last result of the bipolar copy
    wire [11:0] dac_bip, res_bip;
    wire valid_bip;
    int miscompares = 0;
    int n_checks = 0;
    int n_valid = 0;
    int cycles = 0;
    sar_adc_serial_conversion_ctrl #(.FULL_WAKE_CYCLES_P(WAKE)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_serial_clock(serial_clock), .i_convert_start(convert_start),
        .i_cmp_high(i_cmp_high), .o_sdo(o_sdo), .o_sdo_oe_b(o_sdo_oe_b),
        .o_track_hold(o_track_hold), .o_dac_code(o_dac_code),
        .o_result(o_result), .o_result_valid(o_result_valid),
        .o_power_mode(o_power_mode), .o_conv_ready(o_conv_ready)
    );
    sar_host_model u_host (
        .o_serial_clock(serial_clock), .o_convert_start(convert_start),
        .i_sdo(o_sdo), .i_sdo_oe_b(o_sdo_oe_b)
    );
    // bipolar copy on the same link, so the coding choice is exercised
    sar_adc_serial_conversion_ctrl #(
        .BIPOLAR(1'b1), .FULL_WAKE_CYCLES_P(WAKE)
    ) u_dut_bip (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_serial_clock(serial_clock), .i_convert_start(convert_start),
        .i_cmp_high(cmp_bip), .o_sdo(), .o_sdo_oe_b(),
        .o_track_hold(), .o_dac_code(dac_bip), .o_result(res_bip),
        .o_result_valid(valid_bip), .o_power_mode(), .o_conv_ready()
    );
    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // ideal comparator, settled at the fall before each decision
    always @(negedge serial_clock) begin
        i_cmp_high <= (vin >= o_dac_code);
        cmp_bip <= (vin >= dac_bip);
    end
    // collect published results; the cycle ceiling cuts a hang short
    // taken at the falling edge, where the flopped outputs have settled
    always @(negedge i_sys_clk) begin
        cycles++;
        if (o_result_valid === 1'b1) begin
            n_valid++;
            got = o_result;
        end
        if (valid_bip === 1'b1) begin
            got_bip = res_bip;
        end
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] frame_of(input logic [11:0] v);
        return {3'b000, v, 1'b0};
    endfunction : frame_of
    // one conversion of v; hi is the edge that sees the raise (0: none)
    task automatic conv(input logic [11:0] v, input int hi, input int pub);
        int nv;
        nv = n_valid;
        vin = v;
        u_host.frame(16, hi);
        check(u_host.word, frame_of(v));
        check(o_sdo_oe_b, 1'b0);
        if (hi == 0) begin
            u_host.park();
            #1 check(o_sdo_oe_b, 1'b1);
        end
        repeat (8) @(posedge i_sys_clk);
        check(16'(n_valid - nv), 16'(pub));
        if (pub != 0) check(got, v);
        if (pub != 0) check(got_bip, v ^ MSB_FLIP);
    endtask : conv
    // strobe low past the 14th edge leaves either sleep
    task automatic wake();
        u_host.frame(16, 0);
        u_host.park();
        repeat (8) @(posedge i_sys_clk);
        check(o_power_mode, 2'b00);
    endtask : wake
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        int hi;
        void'($urandom(25210));
        // link flops need serial rises while reset is held
        fork
            repeat (4) u_host.tick();
            repeat (8) @(posedge i_sys_clk);
        join
        #1 check(o_sdo_oe_b, 1'b1);
        check(o_conv_ready, 1'b0);
        i_rst_b = 1'b1;
        repeat (3) u_host.tick();
        check(o_track_hold, 1'b0);
        conv(12'h5A5, 0, 0);  // first frame only calibrates
        conv(12'h000, 16, 1);
        conv(12'hFFF, 15, 1);
        for (int i = 0; i < 10; i++) begin
            hi = $urandom_range(2, 0);
            conv(12'($urandom), (hi == 0) ? 0 : 14 + hi, 1);
        end
        // clock runs on with the strobe low: released at edge 17
        vin = 12'h3C3;
        u_host.frame(18, 0);
        check(o_sdo_oe_b, 1'b1);
        u_host.park();
        u_host.frame(4, 4);  // earliest raise that sleeps
        #1 check(o_sdo_oe_b, 1'b1);
        repeat (8) @(posedge i_sys_clk);
        check(o_power_mode, 2'b01);
        u_host.frame(14, 14);  // latest raise that sleeps
        repeat (8) @(posedge i_sys_clk);
        check(o_power_mode, 2'b11);
        wake();
        check(o_conv_ready, 1'b0);
        for (int k = 0; k < 2 * WAKE && o_conv_ready !== 1'b1; k++) begin
            @(posedge i_sys_clk);
        end
        conv(12'h7FF, 0, 1);  // no new calibration after waking
        u_host.frame(5, 5);
        wake();
        check(o_conv_ready, 1'b0);
        conv(12'h800, 0, 0);  // started inside the restart time
        check(o_conv_ready, 1'b1);
        conv(12'h001, 16, 1);
        end_of_test();
    end
endmodule : sar_adc_serial_conversion_ctrl_test
